// *** src/lfs_pkg.sv ***
// Constants for the LED driver fault sequencer.
// Assumes a 125 MHz core clock; all times are converted to cycles here.
package lfs_pkg;
   localparam int unsigned CLK_MHZ = 125;
   // Times in nanoseconds
   localparam int unsigned SYNC_LOW_NS = 7000;
   localparam int unsigned OC2X_MAX_NS = 3000;
   localparam int unsigned UVLO_DEGLITCH_NS = 50000;
   // Least times round up, longest times round down
   localparam int unsigned SYNC_LOW_CYC = (SYNC_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned OC2X_MAX_CYC = (OC2X_MAX_NS * CLK_MHZ) / 1000;
   localparam int unsigned UVLO_CYC = (UVLO_DEGLITCH_NS * CLK_MHZ + 999) / 1000;
   // Counts in switching or clock cycles
   localparam int unsigned OC1X_CYCLES = 10000;
   localparam int unsigned EN_LOW_CYCLES = 32750;
   localparam int unsigned CNT_W = 16;
   // Sequencer states
   typedef enum logic [2:0] {
      LFS_OFF = 3'b000,
      LFS_RUN = 3'b001,
      LFS_OC1X = 3'b010,
      LFS_LATCH = 3'b011,
      LFS_SDOWN = 3'b100
   } lfs_state_t;
endpackage

// *** src/lfs_sync2.sv ***
// Two-flop synchroniser for a bundle of pin levels.
// Assumes inputs are asynchronous to i_core_clk.
`timescale 1ns/10ps
module lfs_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_srst,
   // Levels
   input wire logic [W-1:0] i_async,
   input wire logic [W-1:0] i_rst_val,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;
   logic [W-1:0] nxt_meta;
   logic [W-1:0] nxt_sync;

   always_comb begin
      nxt_meta = i_async;
      nxt_sync = meta_ff;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         meta_ff <= i_rst_val;
         sync_ff <= i_rst_val;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign o_sync = sync_ff;
endmodule

// *** src/lfs_top.sv ***
// Fault and shutdown sequencer of a boost LED driver.
// Assumes analog comparators deliver levels; sw_tick marks each switching cycle start.
// What this block does
// RQ1 - Primary switch limit ends the current switching cycle
// RQ2 - Secondary switch limit shuts down at once
// RQ3 - 1X input overcurrent limited for 10000 cycles
// RQ4 - 1X overcurrent raises fault flag immediately
// RQ5 - 1X cleared early drops flag, resumes
// RQ6 - 1X timer expiry latches shutdown
// RQ7 - Sync low over 7 us forces shutdown
// RQ8 - Enable low 32750 cycles enters low power
// RQ9 - Shutdown clears faults, waits enable high
// RQ10 - 2X input overcurrent shuts down within 3 us
// RQ11 - 2X shutdown latched with fault flag
// RQ12 - Latched fault cleared by long enable low
// RQ13 - UVLO enable on both rising, 50 us fall
// RQ14 - Latched faults also turn gate off
`timescale 1ns/10ps
module lfs_top #(
   parameter int unsigned OC1X_LIMIT = lfs_pkg::OC1X_CYCLES,
   parameter int unsigned EN_LOW_LIMIT = lfs_pkg::EN_LOW_CYCLES
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_srst,
   // Switching cycle marker from the oscillator
   input wire logic i_sw_tick,
   // Comparator levels (asynchronous)
   input wire logic i_sw_ilim1,
   input wire logic i_sw_ilim2,
   input wire logic i_in_oc1x,
   input wire logic i_in_oc2x,
   input wire logic i_vin_above_rise,
   input wire logic i_vin_below_fall,
   input wire logic i_input_sense_node_ok,
   // Host pins (asynchronous)
   input wire logic i_enable_dim_pin,
   input wire logic i_freq_set_sync_pin,
   // Drives
   output logic o_boost_en,
   output logic o_gate_on,
   output logic o_gate_linear,
   output logic o_sink_en,
   output logic o_fault_n,
   output logic o_low_power
);
   // -----------------------------------------------------------------
   // Parameter checks
   // -----------------------------------------------------------------
   if (OC1X_LIMIT < 2 || OC1X_LIMIT >= (1 << lfs_pkg::CNT_W)) begin : g_bad_oc1x
      $error("OC1X_LIMIT out of range");
   end
   if (EN_LOW_LIMIT < 2 || EN_LOW_LIMIT >= (1 << lfs_pkg::CNT_W)) begin : g_bad_en
      $error("EN_LOW_LIMIT out of range");
   end

   // -----------------------------------------------------------------
   // Counter limits
   // -----------------------------------------------------------------
   localparam logic [lfs_pkg::CNT_W-1:0] OC1X_MAX = lfs_pkg::CNT_W'(OC1X_LIMIT - 1);
   localparam logic [lfs_pkg::CNT_W-1:0] EN_MAX = lfs_pkg::CNT_W'(EN_LOW_LIMIT - 1);
   localparam logic [lfs_pkg::CNT_W-1:0] SYNC_MAX = lfs_pkg::CNT_W'(lfs_pkg::SYNC_LOW_CYC);
   localparam logic [lfs_pkg::CNT_W-1:0] UVLO_MAX = lfs_pkg::CNT_W'(lfs_pkg::UVLO_CYC);

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   // Sync pin idles high, so its stage resets high to avoid a false low
   logic [8:0] pins_s;
   lfs_sync2 #(.W(9)) u_sync (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_async({i_sw_ilim1, i_sw_ilim2, i_in_oc1x, i_in_oc2x, i_vin_above_rise,
                i_vin_below_fall, i_input_sense_node_ok, i_enable_dim_pin,
                i_freq_set_sync_pin}),
      .i_rst_val(9'h001),
      .o_sync(pins_s)
   );
   logic ilim1, ilim2, oc1x, oc2x, vin_rise, vin_fall, sense_ok, en_pin, sync_pin;
   assign {ilim1, ilim2, oc1x, oc2x, vin_rise, vin_fall, sense_ok, en_pin, sync_pin} = pins_s;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   // Saturating counter step
   function automatic logic [lfs_pkg::CNT_W-1:0] cnt_step(
      input logic cond, input logic [lfs_pkg::CNT_W-1:0] c, input logic [lfs_pkg::CNT_W-1:0] mx);
      if (!cond) cnt_step = '0;
      else if (c >= mx) cnt_step = mx;
      else cnt_step = c + lfs_pkg::CNT_W'(1);
   endfunction

   // -----------------------------------------------------------------
   // Pin and supply timers
   // -----------------------------------------------------------------
   logic [lfs_pkg::CNT_W-1:0] en_cnt_ff, sync_cnt_ff, uvlo_cnt_ff;
   logic [lfs_pkg::CNT_W-1:0] nxt_en_cnt, nxt_sync_cnt, nxt_uvlo_cnt;
   logic supply_ok_ff, nxt_supply_ok;
   logic en_long_low, sync_long_low;

   always_comb begin
      // Counters saturate so a long low keeps its request standing
      nxt_en_cnt = cnt_step(!en_pin, en_cnt_ff, EN_MAX); // RQ8 RQ12
      nxt_sync_cnt = cnt_step(!sync_pin, sync_cnt_ff, SYNC_MAX); // RQ7
      nxt_uvlo_cnt = cnt_step(vin_fall, uvlo_cnt_ff, UVLO_MAX); // RQ13
      // Supply good on both rising, bad only after the falling deglitch
      nxt_supply_ok = supply_ok_ff;
      if (vin_rise && sense_ok) begin
         nxt_supply_ok = 1'b1; // RQ13
      end else if (uvlo_cnt_ff >= UVLO_MAX) begin
         nxt_supply_ok = 1'b0; // RQ13
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         en_cnt_ff <= '0;
         sync_cnt_ff <= '0;
         uvlo_cnt_ff <= '0;
         supply_ok_ff <= 1'b0;
      end else begin
         en_cnt_ff <= nxt_en_cnt;
         sync_cnt_ff <= nxt_sync_cnt;
         uvlo_cnt_ff <= nxt_uvlo_cnt;
         supply_ok_ff <= nxt_supply_ok;
      end
   end

   assign en_long_low = (en_cnt_ff >= EN_MAX) && !en_pin;
   assign sync_long_low = (sync_cnt_ff >= SYNC_MAX) && !sync_pin;

   // -----------------------------------------------------------------
   // Fault sequencer
   // -----------------------------------------------------------------
   lfs_pkg::lfs_state_t state_ff, nxt_state;
   logic [lfs_pkg::CNT_W-1:0] oc_cnt_ff, nxt_oc_cnt;
   logic skip_ff, nxt_skip;
   logic boost_ff, gate_ff, lin_ff, sink_ff, fault_n_ff, lp_ff;
   logic nxt_boost, nxt_gate, nxt_lin, nxt_sink, nxt_fault_n, nxt_lp;

   always_comb begin
      nxt_state = state_ff;
      nxt_oc_cnt = oc_cnt_ff;
      nxt_skip = skip_ff;
      unique case (state_ff)
         lfs_pkg::LFS_OFF: begin
            if (supply_ok_ff && en_pin) nxt_state = lfs_pkg::LFS_RUN; // RQ9 RQ13
         end
         lfs_pkg::LFS_RUN, lfs_pkg::LFS_OC1X: begin
            // Supply loss first, then hard faults, then host shutdowns
            if (!supply_ok_ff) begin
               nxt_state = lfs_pkg::LFS_OFF; // RQ13
            end else if (ilim2 || oc2x) begin
               nxt_state = lfs_pkg::LFS_LATCH; // RQ2 RQ10 RQ11
            end else if (en_long_low || sync_long_low) begin
               nxt_state = lfs_pkg::LFS_SDOWN; // RQ7 RQ8
            end else if (state_ff == lfs_pkg::LFS_RUN) begin
               if (oc1x) begin
                  nxt_state = lfs_pkg::LFS_OC1X; // RQ3 RQ4
                  nxt_oc_cnt = '0;
               end
            end else if (!oc1x) begin
               nxt_state = lfs_pkg::LFS_RUN; // RQ5
            end else if (i_sw_tick) begin
               if (oc_cnt_ff >= OC1X_MAX) nxt_state = lfs_pkg::LFS_LATCH; // RQ6
               else nxt_oc_cnt = oc_cnt_ff + lfs_pkg::CNT_W'(1); // RQ3
            end
         end
         lfs_pkg::LFS_LATCH: begin
            // Sync pin is ignored here; only a long enable low clears it
            if (en_long_low) nxt_state = lfs_pkg::LFS_SDOWN; // RQ12
         end
         lfs_pkg::LFS_SDOWN: begin
            // Held until enable is high and the sync pin is released
            if (en_pin && !sync_long_low) nxt_state = lfs_pkg::LFS_OFF; // RQ9
         end
         default: nxt_state = lfs_pkg::LFS_OFF;
      endcase
      // Cycle-by-cycle limit: drop the rest of this cycle, resume on next tick
      if (i_sw_tick) nxt_skip = 1'b0; // RQ1
      if (ilim1) nxt_skip = 1'b1; // RQ1
      nxt_boost = (nxt_state == lfs_pkg::LFS_RUN || nxt_state == lfs_pkg::LFS_OC1X)
                  && !nxt_skip; // RQ1
      nxt_sink = (nxt_state == lfs_pkg::LFS_RUN || nxt_state == lfs_pkg::LFS_OC1X);
      nxt_gate = nxt_sink; // RQ14
      nxt_lin = (nxt_state == lfs_pkg::LFS_OC1X); // RQ3
      nxt_fault_n = !(nxt_state == lfs_pkg::LFS_OC1X || nxt_state == lfs_pkg::LFS_LATCH); // RQ4 RQ11
      nxt_lp = (nxt_state == lfs_pkg::LFS_SDOWN) && en_long_low; // RQ8
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         state_ff <= lfs_pkg::LFS_OFF;
         oc_cnt_ff <= '0;
         skip_ff <= 1'b0;
         boost_ff <= 1'b0;
         gate_ff <= 1'b0;
         lin_ff <= 1'b0;
         sink_ff <= 1'b0;
         fault_n_ff <= 1'b1;
         lp_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         oc_cnt_ff <= nxt_oc_cnt;
         skip_ff <= nxt_skip;
         boost_ff <= nxt_boost;
         gate_ff <= nxt_gate;
         lin_ff <= nxt_lin;
         sink_ff <= nxt_sink;
         fault_n_ff <= nxt_fault_n;
         lp_ff <= nxt_lp;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign o_boost_en = boost_ff;
   assign o_gate_on = gate_ff;
   assign o_gate_linear = lin_ff;
   assign o_sink_en = sink_ff;
   assign o_fault_n = fault_n_ff;
   assign o_low_power = lp_ff;
endmodule

// *** bench/lfs_host_model.sv ***
// Host controller model driving the enable/dim and sync pins.
// Assumes tasks are entered just after a rising clock edge.
`timescale 1ns/10ps
module lfs_host_model (
   // Clock
   input wire logic i_core_clk,
   // Host pins
   output logic o_enable_dim_pin,
   output logic o_freq_set_sync_pin
);
   // ------------------------------
   // Pin drive
   // ------------------------------
   initial begin
      o_enable_dim_pin = 1'b0;
      o_freq_set_sync_pin = 1'b1;
   end
   // Holds one pin low for n cycles; sel high picks the sync pin
   task automatic hold_low(input logic sel, input int n);
      if (sel) o_freq_set_sync_pin = 1'b0;
      else o_enable_dim_pin = 1'b0;
      repeat (n) @(posedge i_core_clk);
      #1;
      if (sel) o_freq_set_sync_pin = 1'b1;
      else o_enable_dim_pin = 1'b1;
   endtask
endmodule

// *** bench/lfs_top_assertions.sv ***
// Port checks of the fault sequencer, bound into lfs_top.
// Assumes one core clock and the synchronous active-high reset.
`timescale 1ns/10ps
module lfs_top_assertions #(
   parameter int unsigned EN_LOW_LIMIT = lfs_pkg::EN_LOW_CYCLES
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_srst,
   // Comparators and host pins
   input wire logic i_sw_ilim1,
   input wire logic i_sw_ilim2,
   input wire logic i_in_oc1x,
   input wire logic i_in_oc2x,
   input wire logic i_vin_above_rise,
   input wire logic i_input_sense_node_ok,
   input wire logic i_enable_dim_pin,
   input wire logic i_freq_set_sync_pin,
   // Drives
   input wire logic o_boost_en,
   input wire logic o_gate_on,
   input wire logic o_gate_linear,
   input wire logic o_sink_en,
   input wire logic o_fault_n,
   input wire logic o_low_power
);
   logic [15:0] sync_lo_ff, en_lo_ff;
   // ------------------------------
   // Pin low-time counters
   // ------------------------------
   always_ff @(posedge i_core_clk) begin
      sync_lo_ff <= (i_srst || i_freq_set_sync_pin) ? 16'h0 : sync_lo_ff + {15'h0, ~&sync_lo_ff};
      en_lo_ff <= (i_srst || i_enable_dim_pin) ? 16'h0 : en_lo_ff + {15'h0, ~&en_lo_ff};
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   a_prim_skip: assert property ($rose(i_sw_ilim1) && o_sink_en |-> ##[1:4] !o_boost_en)
      else $error("boost kept on at primary limit");
   a_sec_off: assert property ($rose(i_sw_ilim2) && o_gate_on |-> ##[1:5]
      (!o_gate_on && !o_boost_en && !o_sink_en && !o_fault_n)) else $error("secondary limit");
   a_oc2x_off: assert property ($rose(i_in_oc2x) && o_gate_on |-> ##[1:5]
      (!o_gate_on && !o_boost_en && !o_sink_en && !o_fault_n)) else $error("2X shutdown");
   a_oc1x_flag: assert property ($rose(i_in_oc1x) && o_sink_en && !i_in_oc2x |-> ##[1:5]
      (!o_fault_n && o_gate_linear && o_gate_on)) else $error("1X flag or linear");
   a_latch_hold: assert property (i_enable_dim_pin[*4] ##0 (!o_fault_n && !o_gate_on)
      |=> (!o_fault_n && !o_gate_on)) else $error("latched fault left");
   a_sync_sdown: assert property (sync_lo_ff >= lfs_pkg::SYNC_LOW_CYC + 5
      |-> !(o_boost_en || o_gate_on || o_sink_en)) else $error("sync shutdown");
   a_en_lowpwr: assert property (en_lo_ff >= EN_LOW_LIMIT + 5
      |-> o_low_power && o_fault_n && !o_sink_en && !o_gate_on) else $error("low power");
   a_lp_cause: assert property ($rose(o_low_power) |-> en_lo_ff >= EN_LOW_LIMIT)
      else $error("low power too early");
   a_uvlo_rise: assert property ($rose(o_sink_en)
      |-> $past(i_vin_above_rise, 3) && $past(i_input_sense_node_ok, 3)) else $error("uvlo");
   cover property ($rose(o_low_power));
   cover property ($rose(o_gate_linear));
   cover property ($fell(o_gate_on) && !o_fault_n);
endmodule
bind lfs_top lfs_top_assertions #(.EN_LOW_LIMIT(EN_LOW_LIMIT)) u_lfs_top_assertions (
   .i_core_clk(i_core_clk), .i_srst(i_srst),
   .i_sw_ilim1(i_sw_ilim1), .i_sw_ilim2(i_sw_ilim2),
   .i_in_oc1x(i_in_oc1x), .i_in_oc2x(i_in_oc2x),
   .i_vin_above_rise(i_vin_above_rise), .i_input_sense_node_ok(i_input_sense_node_ok),
   .i_enable_dim_pin(i_enable_dim_pin), .i_freq_set_sync_pin(i_freq_set_sync_pin),
   .o_boost_en(o_boost_en), .o_gate_on(o_gate_on), .o_gate_linear(o_gate_linear),
   .o_sink_en(o_sink_en), .o_fault_n(o_fault_n), .o_low_power(o_low_power)
);

// *** bench/lfs_top_tb.sv ***
// Self-checking bench of the fault sequencer with a host pin model.
// Assumes lfs_pkg, the design and the bench modules are compiled first.
`timescale 1ns/10ps
module lfs_top_tb;
   logic i_core_clk = 1'b0, i_srst = 1'b1, tick = 1'b0, il1 = 1'b0, il2 = 1'b0;
   logic oc1 = 1'b0, oc2 = 1'b0, rise = 1'b0, fall = 1'b1, sok = 1'b0;
   wire en, syn;
   wire [5:0] outs;
   logic [5:0] exp_q[$];
   int failures = 0, total_checks = 0, seed = 14648, cyc = 0;
   event smp;
   always #4 i_core_clk = ~i_core_clk;
   lfs_top #(.OC1X_LIMIT(8), .EN_LOW_LIMIT(16)) u_lfs_top (
      .i_core_clk(i_core_clk), .i_srst(i_srst), .i_sw_tick(tick), .i_sw_ilim1(il1),
      .i_sw_ilim2(il2), .i_in_oc1x(oc1), .i_in_oc2x(oc2), .i_vin_above_rise(rise),
      .i_vin_below_fall(fall), .i_input_sense_node_ok(sok), .i_enable_dim_pin(en),
      .i_freq_set_sync_pin(syn), .o_boost_en(outs[5]), .o_gate_on(outs[4]),
      .o_gate_linear(outs[3]), .o_sink_en(outs[2]), .o_fault_n(outs[1]),
      .o_low_power(outs[0]));
   lfs_host_model u_lfs_host_model (.i_core_clk(i_core_clk), .o_enable_dim_pin(en),
      .o_freq_set_sync_pin(syn));
   // ------------------------------
   // Checking and pacing
   // ------------------------------
   task automatic check(input logic [5:0] seen, input logic [5:0] want);
      total_checks++;
      if (seen !== want) begin
         failures++;
         $display("[FAIL] %0t outputs %b expected %b", $time, seen, want);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask
   // Outputs ordered boost, gate, linear, sink, fault_n, low power
   task automatic expect_o(input logic [5:0] v, input int n);
      step(n);
      exp_q.push_back(v);
      ->smp;
   endtask
   always @(smp) check(outs, exp_q.pop_front());
   task automatic clear_latch();
      fork
         u_lfs_host_model.hold_low(1'b0, 24);
         expect_o(6'h03, 22);
      join
      expect_o(6'h36, 12);
   endtask
   task automatic stop_test();
      $display("Checks %0d, failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge i_core_clk) begin
      #1;
      tick = 1'($random(seed));
      cyc++;
      if (cyc > 20000) begin
         failures++;
         stop_test();
      end
   end
   // ------------------------------
   // Scenarios
   // ------------------------------
   initial begin
      step(4);
      i_srst = 1'b0;
      rise = 1'b1;
      fall = 1'b0;
      sok = 1'b1;
      step(2);
      u_lfs_host_model.hold_low(1'b0, 2);
      expect_o(6'h36, 12);
      oc1 = 1'b1;
      expect_o(6'h3C, 6);
      oc1 = 1'b0;
      expect_o(6'h36, 6);
      oc1 = 1'b1;
      expect_o(6'h00, 100);
      oc1 = 1'b0;
      clear_latch();
      oc2 = 1'b1;
      expect_o(6'h00, 5);
      oc2 = 1'b0;
      expect_o(6'h00, 20);
      clear_latch();
      il2 = 1'b1;
      expect_o(6'h00, 5);
      il2 = 1'b0;
      clear_latch();
      il1 = 1'b1;
      expect_o(6'h16, 4);
      il1 = 1'b0;
      expect_o(6'h36, 20);
      fork
         u_lfs_host_model.hold_low(1'b1, 100);
         expect_o(6'h36, 99);
      join
      // One high cycle restarts the sync low timer before the long pulse
      step(1);
      fork
         u_lfs_host_model.hold_low(1'b1, 900);
         expect_o(6'h02, 890);
      join
      expect_o(6'h36, 12);
      rise = 1'b0;
      fall = 1'b1;
      expect_o(6'h36, 100);
      expect_o(6'h02, 6300);
      rise = 1'b1;
      fall = 1'b0;
      sok = 1'b0;
      expect_o(6'h02, 12);
      sok = 1'b1;
      expect_o(6'h36, 12);
      stop_test();
   end
endmodule
